// File: cond_branch_pkg.sv
package cond_branch_pkg;

    // instruction field positions
    localparam int OPCODE_HI = 31;
    localparam int OPCODE_LO = 26;
    localparam int FIRST_SRC_HI = 25;
    localparam int FIRST_SRC_LO = 21;
    localparam int SECOND_SRC_HI = 20;
    localparam int SECOND_SRC_LO = 16;
    localparam int OFFSET_HI = 15;
    localparam int OFFSET_LO = 0;
    localparam int COP_FMT_HI = 25;
    localparam int COP_FMT_LO = 21;
    localparam int SELECTOR_HI = 20;
    localparam int SELECTOR_LO = 18;
    localparam int NULLIFY_BIT = 17;
    localparam int TRUE_FALSE_BIT = 16;

    // encodings
    localparam logic [5:0] OP_REGISTER_IMMEDIATE_CLASS = 6'h01;
    localparam logic [5:0] OP_BRANCH_ON_EQUAL = 6'h04;
    localparam logic [5:0] OP_BRANCH_ON_EQUAL_LIKELY = 6'h14;
    localparam logic [5:0] OP_COPROCESSOR_TWO = 6'h12;
    localparam logic [4:0] COP_FMT_BRANCH = 5'h08;
    localparam logic [4:0] RI_BRANCH_ON_NONNEGATIVE = 5'h01;
    localparam logic [4:0] RI_BRANCH_NONNEGATIVE_LINK = 5'h11;
    localparam logic [4:0] RI_BRANCH_NONNEGATIVE_LINK_LIKELY = 5'h13;

    // architectural constants
    localparam logic [4:0] LINK_REG = 5'h1f;
    localparam logic [31:0] LINK_STEP = 32'h0000_0008;
    localparam logic [31:0] SLOT_STEP = 32'h0000_0004;
    localparam int OFFSET_SHIFT = 2;
    localparam int SCALED_WIDTH = 18;

    // reset values
    localparam logic [31:0] PC_RESET = 32'h0000_0000;

    typedef enum logic [1:0] {
        IDLE,
        IN_SLOT
    } slot_state_t;

endpackage : cond_branch_pkg

// File: branch_target_calc.sv
`timescale 1ns/10ps

module branch_target_calc #(
    parameter int XLEN = 32
) (
    // operands
    input wire logic [XLEN-1:0] branchPc,
    input wire logic [15:0] offsetField,
    // results
    output logic [XLEN-1:0] target,
    output logic [XLEN-1:0] linkAddr
);

    logic [cond_branch_pkg::SCALED_WIDTH-1:0] scaled;
    logic [XLEN-1:0] wideOffset;
    logic [XLEN-1:0] slotPc;

    // the step constants are 32 bits wide, so wider words are refused
    if (XLEN < cond_branch_pkg::SCALED_WIDTH
        || XLEN > 32) begin : g_width_check
        $error("XLEN out of range for the scaled offset");
    end

    // 18-bit scaled offset, widened by sign before the add
    assign scaled = {offsetField, 2'b00};
    assign wideOffset = {{(XLEN-cond_branch_pkg::SCALED_WIDTH){scaled[17]}},
                         scaled};
    // relative to the delay slot, not to the branch itself
    assign slotPc = branchPc + cond_branch_pkg::SLOT_STEP[XLEN-1:0];
    assign target = slotPc + wideOffset;
    assign linkAddr = branchPc + cond_branch_pkg::LINK_STEP[XLEN-1:0];

endmodule : branch_target_calc

// File: cond_branch_resolve.sv
`timescale 1ns/10ps

module cond_branch_resolve #(
    parameter int XLEN = 32
) (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // issue from the pipeline: one instruction per valid cycle
    input wire logic issueValid,
    input wire logic [31:0] instrWord,
    input wire logic [XLEN-1:0] instrPc,
    input wire logic [XLEN-1:0] firstSourceValue,
    input wire logic [XLEN-1:0] secondSourceValue,
    // coprocessor two state
    input wire logic [7:0] coprocCondition,
    input wire logic coprocUsable,
    input wire logic coprocPresent,
    // exception taken on the delay-slot instruction
    input wire logic slotException,
    // link write
    output logic linkWrite,
    output logic [4:0] linkReg,
    output logic [XLEN-1:0] linkData,
    // redirect and slot control
    output logic redirect,
    output logic [XLEN-1:0] redirectPc,
    output logic nullifySlot,
    output logic branchTaken,
    // exceptions
    output logic coprocUnusableExc,
    output logic reservedInstrExc,
    output logic [XLEN-1:0] restartPc
);

    if (XLEN != 32) begin : g_width_check
        $error("register width must be 32");
    end

    ////////////////////////////////////////////////////////////////////////
    // decode

    logic [5:0] opcode;
    logic [4:0] riField;
    logic [4:0] copFmt;
    logic [2:0] conditionSelector;
    logic nullifySlotSelect;
    logic trueFalseSelect;
    logic isEqual, isEqualLikely, isNonneg, isNonnegLink, isNonnegLinkLikely;
    logic isCoproc, isBranch, isLink, isLikely, condition;
    logic [XLEN-1:0] target, linkAddr;

    assign opcode = instrWord[cond_branch_pkg::OPCODE_HI:
                              cond_branch_pkg::OPCODE_LO];
    assign riField = instrWord[cond_branch_pkg::SECOND_SRC_HI:
                               cond_branch_pkg::SECOND_SRC_LO];
    assign copFmt = instrWord[cond_branch_pkg::COP_FMT_HI:
                              cond_branch_pkg::COP_FMT_LO];
    // an omitted selector assembles as zero, so field value 0 covers it
    assign conditionSelector = instrWord[cond_branch_pkg::SELECTOR_HI:
                                         cond_branch_pkg::SELECTOR_LO];
    assign nullifySlotSelect = instrWord[cond_branch_pkg::NULLIFY_BIT];
    assign trueFalseSelect = instrWord[cond_branch_pkg::TRUE_FALSE_BIT];

    function automatic logic isImmClass(input logic [5:0] op,
        input logic [4:0] fld, input logic [4:0] code);
        return op == cond_branch_pkg::OP_REGISTER_IMMEDIATE_CLASS
            && fld == code;
    endfunction : isImmClass

    assign isEqual = opcode == cond_branch_pkg::OP_BRANCH_ON_EQUAL;
    assign isEqualLikely = opcode
        == cond_branch_pkg::OP_BRANCH_ON_EQUAL_LIKELY;
    assign isNonneg = isImmClass(opcode, riField,
        cond_branch_pkg::RI_BRANCH_ON_NONNEGATIVE);
    assign isNonnegLink = isImmClass(opcode, riField,
        cond_branch_pkg::RI_BRANCH_NONNEGATIVE_LINK);
    assign isNonnegLinkLikely = isImmClass(opcode, riField,
        cond_branch_pkg::RI_BRANCH_NONNEGATIVE_LINK_LIKELY);
    assign isCoproc = opcode == cond_branch_pkg::OP_COPROCESSOR_TWO
        && copFmt == cond_branch_pkg::COP_FMT_BRANCH;

    assign isLink = isNonnegLink | isNonnegLinkLikely;
    assign isLikely = isEqualLikely | isNonnegLinkLikely
        | (isCoproc & nullifySlotSelect);
    assign isBranch = isEqual | isEqualLikely | isNonneg | isLink | isCoproc;

    ////////////////////////////////////////////////////////////////////////
    // condition: full-width compares, so register 0 against itself is
    // always equal and register 0 is always nonnegative

    always_comb begin
        condition = 1'b0;
        if (isEqual || isEqualLikely) begin
            condition = firstSourceValue == secondSourceValue;
        end else if (isNonneg || isLink) begin
            condition = ~firstSourceValue[XLEN-1];
        end else if (isCoproc) begin
            condition = coprocCondition[conditionSelector]
                == trueFalseSelect;
        end
    end

    branch_target_calc #(
        .XLEN(XLEN)
    ) u_target (
        .branchPc(instrPc),
        .offsetField(instrWord[cond_branch_pkg::OFFSET_HI:
                               cond_branch_pkg::OFFSET_LO]),
        .target(target),
        .linkAddr(linkAddr)
    );

    ////////////////////////////////////////////////////////////////////////
    // coprocessor exceptions; a faulting branch does not resolve

    logic copFault, copUnusable, resolve;
    assign copUnusable = isCoproc & ~coprocUsable;
    assign copFault = isCoproc & (~coprocUsable | ~coprocPresent);
    assign resolve = issueValid & isBranch & ~copFault;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            coprocUnusableExc <= 1'b0;
            reservedInstrExc <= 1'b0;
        end else begin
            coprocUnusableExc <= issueValid & copUnusable;
            reservedInstrExc <= issueValid & isCoproc & coprocUsable
                & ~coprocPresent;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // link write, in the cycle after issue, taken or not

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            linkWrite <= 1'b0;
            linkReg <= 5'h00;
            linkData <= cond_branch_pkg::PC_RESET;
        end else begin
            linkWrite <= resolve & isLink;
            if (resolve && isLink) begin
                linkReg <= cond_branch_pkg::LINK_REG;
                linkData <= linkAddr;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // slot tracking: branch resolved at issue, PC applied after the slot

    cond_branch_pkg::slot_state_t state_q;
    logic taken_q;
    logic likely_q;
    logic [XLEN-1:0] target_q;
    logic [XLEN-1:0] branchPc_q;
    logic slotDone;

    // the slot has executed once the next instruction issues cleanly
    assign slotDone = state_q == cond_branch_pkg::IN_SLOT
        && issueValid && !slotException;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= cond_branch_pkg::IDLE;
            taken_q <= 1'b0;
            likely_q <= 1'b0;
            target_q <= cond_branch_pkg::PC_RESET;
            branchPc_q <= cond_branch_pkg::PC_RESET;
        end else begin
            case (state_q)
                cond_branch_pkg::IDLE: begin
                    if (resolve) begin
                        state_q <= cond_branch_pkg::IN_SLOT;
                        taken_q <= condition;
                        likely_q <= isLikely;
                        target_q <= target;
                        branchPc_q <= instrPc;
                    end
                end
                cond_branch_pkg::IN_SLOT: begin
                    // fault in the slot drops the pending redirect
                    if (slotException || issueValid) begin
                        state_q <= cond_branch_pkg::IDLE;
                    end
                end
                default: state_q <= cond_branch_pkg::IDLE;
            endcase
        end
    end

    // non-likely: slot always runs; likely and not taken: slot cancelled
    assign nullifySlot = state_q == cond_branch_pkg::IN_SLOT
        && likely_q && !taken_q;
    assign branchTaken = state_q == cond_branch_pkg::IN_SLOT && taken_q;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            redirect <= 1'b0;
            redirectPc <= cond_branch_pkg::PC_RESET;
            restartPc <= cond_branch_pkg::PC_RESET;
        end else begin
            redirect <= slotDone && taken_q;
            if (slotDone && taken_q) begin
                redirectPc <= target_q;
            end
            if (state_q == cond_branch_pkg::IN_SLOT && slotException) begin
                restartPc <= branchPc_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    a_link_on_issue: assert property (@(posedge clock)
        disable iff (sys_rst) issueValid && isLink |=> linkWrite
        && linkReg == 5'h1f && linkData == $past(instrPc) + 32'h8)
        else $error("link not written after linking branch");

    a_nonneg_taken: assert property (@(posedge clock)
        disable iff (sys_rst) state_q == cond_branch_pkg::IDLE && resolve
        && isNonneg |=> taken_q == ~$past(firstSourceValue[XLEN-1]))
        else $error("nonnegative condition wrong");

    a_equal_taken: assert property (@(posedge clock)
        disable iff (sys_rst) state_q == cond_branch_pkg::IDLE && resolve
        && isEqual |=> taken_q == $past(firstSourceValue == secondSourceValue))
        else $error("equal condition wrong");

    a_target_slot: assert property (@(posedge clock)
        disable iff (sys_rst) state_q == cond_branch_pkg::IDLE && resolve
        |=> target_q == $past(instrPc) + 32'h4
        + {{14{$past(instrWord[15])}}, $past(instrWord[15:0]), 2'b00})
        else $error("target not slot relative");

    sequence s_branch_armed;
        state_q == cond_branch_pkg::IN_SLOT && taken_q;
    endsequence
    sequence s_slot_runs;
        issueValid && !slotException;
    endsequence
    a_redirect_after: assert property (@(posedge clock)
        disable iff (sys_rst) s_branch_armed ##0 s_slot_runs |=> redirect
        && redirectPc == $past(target_q))
        else $error("redirect missing after slot");

    a_no_early_jump: assert property (@(posedge clock)
        disable iff (sys_rst) state_q == cond_branch_pkg::IDLE && resolve
        |=> !redirect)
        else $error("redirect before slot executed");

    a_likely_nullify: assert property (@(posedge clock)
        disable iff (sys_rst) state_q == cond_branch_pkg::IDLE && resolve
        && isLikely && !condition |=> nullifySlot)
        else $error("likely slot not nullified");

    a_plain_no_null: assert property (@(posedge clock)
        disable iff (sys_rst) state_q == cond_branch_pkg::IDLE && resolve
        && !isLikely |=> !nullifySlot)
        else $error("non-likely slot nullified");

    a_cop_unusable: assert property (@(posedge clock)
        disable iff (sys_rst) issueValid && isCoproc && !coprocUsable
        |=> coprocUnusableExc && !redirect)
        else $error("coprocessor unusable not raised");

    a_slot_restart: assert property (@(posedge clock)
        disable iff (sys_rst) state_q == cond_branch_pkg::IN_SLOT
        && slotException |=> restartPc == $past(branchPc_q) && !redirect)
        else $error("slot fault not restarting at branch");

endmodule : cond_branch_resolve

// File: coproc_cond_model.sv
`timescale 1ns/10ps

module coproc_cond_model (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // setting from the bench
    input wire logic loadCond,
    input wire logic [7:0] condIn,
    input wire logic [1:0] modeIn,
    // state seen by the branch logic
    output logic [7:0] coprocCondition,
    output logic coprocUsable,
    output logic coprocPresent
);
    // a compare writes the bits; they settle one edge later
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            coprocCondition <= 8'h00;
            coprocUsable <= 1'b0;
            coprocPresent <= 1'b0;
        end else if (loadCond) begin
            coprocCondition <= condIn;
            coprocUsable <= modeIn[0];
            coprocPresent <= modeIn[1];
        end
    end
endmodule : coproc_cond_model

// File: cond_branch_resolve_test.sv
`timescale 1ns/10ps

module cond_branch_resolve_test;
    logic clock, sys_rst, issueValid, slotException, loadCond;
    logic [31:0] instrWord, instrPc, firstSourceValue, secondSourceValue;
    logic [7:0] coprocCondition, condIn;
    logic [1:0] modeIn;
    logic coprocUsable, coprocPresent, linkWrite, redirect, nullifySlot;
    logic branchTaken, coprocUnusableExc, reservedInstrExc;
    logic [4:0] linkReg;
    logic [31:0] linkData, redirectPc, restartPc;
    int n_errors = 0;
    int check_count = 0;
    int cycles = 0;

    cond_branch_resolve cond_branch_resolve_i (.clock(clock),
        .sys_rst(sys_rst), .issueValid(issueValid), .instrWord(instrWord),
        .instrPc(instrPc), .firstSourceValue(firstSourceValue),
        .secondSourceValue(secondSourceValue),
        .coprocCondition(coprocCondition), .coprocUsable(coprocUsable),
        .coprocPresent(coprocPresent), .slotException(slotException),
        .linkWrite(linkWrite), .linkReg(linkReg), .linkData(linkData),
        .redirect(redirect), .redirectPc(redirectPc),
        .nullifySlot(nullifySlot), .branchTaken(branchTaken),
        .coprocUnusableExc(coprocUnusableExc),
        .reservedInstrExc(reservedInstrExc), .restartPc(restartPc));

    coproc_cond_model coproc_cond_model_i (.clock(clock), .sys_rst(sys_rst),
        .loadCond(loadCond), .condIn(condIn), .modeIn(modeIn),
        .coprocCondition(coprocCondition), .coprocUsable(coprocUsable),
        .coprocPresent(coprocPresent));

    always #4 clock = ~clock;

    ////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : test_done

    // a whole run lasts about 70 cycles
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            n_errors++;
            test_done();
        end
    end

    task automatic chk(input string name, input logic [31:0] exp,
        input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask : chk

    function automatic logic [31:0] eqw(input logic likely,
        input logic [4:0] srcA, input logic [4:0] srcB,
        input logic [15:0] off);
        eqw = {likely ? 6'h14 : 6'h04, srcA, srcB, off};
    endfunction : eqw

    function automatic logic [31:0] riw(input logic [4:0] code,
        input logic [4:0] srcA, input logic [15:0] off);
        riw = {6'h01, srcA, code, off};
    endfunction : riw

    function automatic logic [31:0] cpw(input logic [2:0] sel,
        input logic nullSel, input logic trueSel);
        cpw = {6'h12, 5'h08, sel, nullSel, trueSel, 16'h8000};
    endfunction : cpw

    task automatic cpset(input logic [7:0] cond, input logic [1:0] mode);
        @(posedge clock);
        loadCond <= 1'b1;
        condIn <= cond;
        modeIn <= mode;
        @(posedge clock);
        loadCond <= 1'b0;
    endtask : cpset

    // branch, then a plain slot instruction, then look for the redirect
    task automatic run_branch(input string name, input logic [31:0] word,
        input logic [31:0] a, input logic [31:0] b, input logic fault,
        input logic expTaken, input logic expNull, input logic expLink);
        logic [31:0] pc;
        logic [31:0] target;
        pc = 32'h0000_1000;
        target = pc + 32'h4 + {{14{word[15]}}, word[15:0], 2'b00};
        @(posedge clock);
        issueValid <= 1'b1;
        instrWord <= word;
        instrPc <= pc;
        firstSourceValue <= a;
        secondSourceValue <= b;
        @(posedge clock);
        instrWord <= 32'h0000_0000;
        instrPc <= pc + 32'h4;
        slotException <= fault;
        #1;
        chk("linkWrite", expLink, linkWrite);
        if (expLink) begin
            chk("linkReg", 32'h1f, linkReg);
            chk("linkData", pc + 32'h8, linkData);
        end
        chk("branchTaken", expTaken, branchTaken);
        chk("nullifySlot", expNull, nullifySlot);
        chk("coprocUnusableExc", 1'b0, coprocUnusableExc);
        chk("reservedInstrExc", 1'b0, reservedInstrExc);
        @(posedge clock);
        issueValid <= 1'b0;
        slotException <= 1'b0;
        #1;
        chk("redirect", expTaken & ~fault, redirect);
        if (expTaken && !fault) begin
            chk("redirectPc", target, redirectPc);
        end
        if (fault) begin
            chk("restartPc", pc, restartPc);
        end
        $display("test %s done", name);
    endtask : run_branch

    task automatic exc_branch(input string name, input logic [1:0] mode,
        input logic expUn, input logic expRes);
        cpset(8'hff, mode);
        @(posedge clock);
        issueValid <= 1'b1;
        instrWord <= cpw(3'h0, 1'b1, 1'b1);
        @(posedge clock);
        issueValid <= 1'b0;
        #1;
        chk("coprocUnusableExc", expUn, coprocUnusableExc);
        chk("reservedInstrExc", expRes, reservedInstrExc);
        @(posedge clock);
        #1;
        chk("redirect", 1'b0, redirect);
        $display("test %s done", name);
    endtask : exc_branch

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        sys_rst = 1'b1;
        issueValid = 1'b0;
        slotException = 1'b0;
        loadCond = 1'b0;
        condIn = 8'h00;
        modeIn = 2'b00;
        instrWord = 32'h0000_0000;
        instrPc = 32'h0000_0000;
        firstSourceValue = 32'h0000_0000;
        secondSourceValue = 32'h0000_0000;
        repeat (10) @(posedge clock);
        sys_rst <= 1'b0;
        #1;
        chk("linkWrite", 1'b0, linkWrite);
        chk("redirect", 1'b0, redirect);
        chk("restartPc", 32'h0, restartPc);
        $display("test reset done");
        run_branch("eq", eqw(0, 3, 4, 16'hfffe), 32'h8000_0001,
            32'h8000_0001, 0, 1, 0, 0);
        run_branch("eq msb", eqw(0, 3, 4, 16'h0004), 32'h0000_0001,
            32'h8000_0001, 0, 0, 0, 0);
        run_branch("eq zero", eqw(0, 0, 0, 16'h7fff), 0, 0, 0, 1, 0,
            0);
        run_branch("eql miss", eqw(1, 3, 4, 16'h0010), 32'h5, 32'h6, 0, 0,
            1, 0);
        run_branch("eql hit", eqw(1, 3, 4, 16'h8000), 32'h6, 32'h6, 0, 1,
            0, 0);
        run_branch("nonneg max", riw(5'h01, 5, 16'h0010), 32'h7fff_ffff, 0,
            0, 1, 0, 0);
        run_branch("nonneg neg", riw(5'h01, 5, 16'h0010), 32'h8000_0000, 0,
            0, 0, 0, 0);
        run_branch("link zero", riw(5'h11, 0, 16'h0008), 0, 0, 0, 1, 0,
            1);
        run_branch("link neg", riw(5'h11, 2, 16'h0008), 32'hffff_ffff, 0,
            0, 0, 0, 1);
        run_branch("linkl neg", riw(5'h13, 2, 16'h0020), 32'h8000_0000, 0,
            0, 0, 1, 1);
        run_branch("linkl pos", riw(5'h13, 2, 16'hff00), 0, 0, 0, 1, 0,
            1);
        run_branch("slot fault", eqw(0, 3, 4, 16'h0040), 32'h9, 32'h9, 1,
            1, 0, 0);
        cpset(8'h20, 2'b11);
        run_branch("cp true", cpw(3'h5, 0, 1), 0, 0, 0, 1, 0, 0);
        run_branch("cp truel", cpw(3'h0, 1, 1), 0, 0, 0, 0, 1, 0);
        run_branch("cp false", cpw(3'h0, 0, 0), 0, 0, 0, 1, 0, 0);
        run_branch("cp falsel", cpw(3'h5, 1, 0), 0, 0, 0, 0, 1, 0);
        exc_branch("unusable", 2'b10, 1, 0);
        exc_branch("reserved", 2'b01, 0, 1);
        test_done();
    end
endmodule : cond_branch_resolve_test
